// ---- verilog/dei_pkg.sv ----
// Holds the register map, field positions, reset values and carriers of the event block.
// Assumes a single device clock and a byte-wide register port behind the serial interface.
package dei_pkg;

  // ****************************************************************
  // Register offsets
  // ****************************************************************
  localparam logic [6:0] OFS_IRQ_ENABLE_GROUP_B  = 7'h04; // Group B interrupt enables.
  localparam logic [6:0] OFS_EVENT_FLAGS_GROUP_A = 7'h05; // Group A sticky flags.
  localparam logic [6:0] OFS_EVENT_FLAGS_GROUP_B = 7'h06; // Group B sticky flags.
  localparam logic [6:0] OFS_IRQ_ROUTE_GROUP_A   = 7'h07; // Group A line select.
  localparam logic [6:0] OFS_IRQ_ROUTE_GROUP_B   = 7'h08; // Group B line select.
  localparam logic [6:0] OFS_SHARED_PIN_USAGE    = 7'h09; // Shared pin usage.
  localparam logic [6:0] OFS_RX_LOOP_CONTROL     = 7'h0A; // Delay loop control.
  localparam logic [6:0] OFS_RX_WARNING_CONTROL  = 7'h0B; // Warning clear control.
  localparam logic [6:0] OFS_RX_RESERVED_CONTROL = 7'h0C; // Reserved tuning byte.

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [7:0] RST_ZERO             = 8'h00; // Reset of cleared registers.
  localparam logic [7:0] RST_RX_LOOP_CONTROL  = 8'h40; // Duty correction on.
  localparam logic [7:0] RST_RX_WARNING_CTRL  = 8'h39; // Reserved default.
  localparam logic [7:0] RST_RX_RESERVED_CTRL = 8'h64; // Reserved default.

  // ****************************************************************
  // Field positions and masks
  // ****************************************************************
  localparam int BIT_PARITY_FAIL  = 7; // Group B parity failure.
  localparam int BIT_SAMPLE_FAIL  = 6; // Group B sample compare failure.
  localparam int BIT_DLL_WARN     = 5; // Group B delay loop warning.
  localparam int BIT_DLL_LOCKED   = 4; // Group B delay loop locked.
  localparam int BIT_FIFO_UNDER   = 2; // Group B FIFO underflow.
  localparam int BIT_FIFO_OVER    = 1; // Group B FIFO overflow.
  localparam int BIT_SYNC_LOST    = 6; // Group A sync lost.
  localparam int BIT_SYNC_LOCKED  = 5; // Group A sync locked.
  localparam int BIT_SYNC_DONE    = 4; // Group A sync done.
  localparam int BIT_MULT_LOST    = 3; // Group A multiplier lost.
  localparam int BIT_MULT_LOCKED  = 2; // Group A multiplier locked.
  localparam logic [7:0] MASK_GROUP_A = 8'h7C; // Implemented group A bits.
  localparam logic [7:0] MASK_GROUP_B = 8'hF6; // Implemented group B bits.
  localparam logic [7:0] MASK_PIN_USAGE = 8'h33; // Implemented usage bits.
  localparam logic [7:0] MASK_LOOP_CTRL = 8'hCF; // Implemented loop control bits.
  localparam int BIT_PARITY_IN_USE  = 5; // Parity usage bit.
  localparam int BIT_FRAMING_IN_USE = 4; // Frame usage bit.
  localparam int BIT_DLL_ENABLE     = 7; // Delay loop enable.
  localparam int BIT_DUTY_CORR      = 6; // Duty correction enable.
  localparam int BIT_OFFSET_SIGN    = 3; // Sign of the phase offset.
  localparam int BIT_WARN_CLEAR     = 7; // Warning clear command.

  // ****************************************************************
  // Shared pin function codes
  // ****************************************************************
  localparam logic [1:0] PIN_NONE     = 2'h0; // Pin has no effect.
  localparam logic [1:0] PIN_PARITY   = 2'h1; // Pin carries parity.
  localparam logic [1:0] PIN_FRAME    = 2'h2; // Pin carries frame.
  localparam logic [1:0] PIN_RESERVED = 2'h3; // Reserved code.

  // ****************************************************************
  // Phase figures in hundredths of a degree
  // ****************************************************************
  localparam logic [14:0] PHASE_BASE_X100 = 15'h2328; // 90.00 degrees.
  localparam logic [14:0] PHASE_STEP_X100 = 15'h0465; // 11.25 degrees.

  // ****************************************************************
  // Carriers
  // ****************************************************************
  // Group A event pulses from the sync unit and clock multiplier.
  typedef struct packed {
    logic sync_lost;
    logic sync_locked;
    logic sync_done;
    logic mult_lost;
    logic mult_locked;
  } dei_group_a_s;

  // Group B event pulses from the receiver, checkers and FIFO.
  typedef struct packed {
    logic parity_fail;
    logic sample_fail;
    logic dll_warn;
    logic dll_locked;
    logic fifo_under;
    logic fifo_over;
  } dei_group_b_s;

  // Receiver control settings driven to the data interface.
  typedef struct packed {
    logic        dll_enable;
    logic        duty_corr_en;
    logic [3:0]  phase_offset;
    logic [14:0] phase_x100;
    logic        parity_sel;
    logic        frame_sel;
    logic        parity_in_use;
    logic        framing_in_use;
  } dei_rx_ctrl_s;

endpackage

// ---- verilog/dei_event_irq.sv ----
// Holds the event flags, interrupt gating and routing, and receiver control registers.
// Assumes a byte register port from the serial interface, synchronous event pulses,
// and that the group A enable register and receiver status live elsewhere.
`timescale 1ns/100ps

module dei_event_irq
(
  input  wire logic                  clk,                 // 40 MHz device clock.
  input  wire logic                  resetn,              // Synchronous reset, active low.
  input  wire logic [6:0]            reg_addr,            // Register offset.
  input  wire logic [7:0]            reg_wdata,           // Write data.
  input  wire logic                  reg_wr,              // Write strobe.
  input  wire logic                  reg_rd,              // Read strobe.
  output logic      [7:0]            reg_rdata,           // Read data, one cycle after strobe.
  input  wire dei_pkg::dei_group_a_s ev_a,                // Group A event pulses.
  input  wire dei_pkg::dei_group_b_s ev_b,                // Group B event pulses.
  input  wire logic [7:0]            irq_enable_group_a,  // External group A enables.
  input  wire logic [7:0]            flag_clear_a,        // Clear mask for group A flags.
  input  wire logic [7:0]            flag_clear_b,        // Clear mask for group B flags.
  output logic                       request_line_a,      // First interrupt request line.
  output logic                       request_line_b,      // Second interrupt request line.
  output dei_pkg::dei_rx_ctrl_s      rx_ctrl,             // Receiver control settings.
  output logic                       rx_warn_clear        // One-cycle warning clear pulse.
);

  // ****************************************************************
  // Register storage
  // ****************************************************************
  logic [7:0] irq_enable_group_b;   // Group B enables.
  logic [7:0] event_flags_group_a;  // Group A sticky flags.
  logic [7:0] event_flags_group_b;  // Group B sticky flags.
  logic [7:0] irq_route_group_a;    // Group A line select.
  logic [7:0] irq_route_group_b;    // Group B line select.
  logic [7:0] shared_pin_usage;     // Shared pin usage.
  logic [7:0] rx_loop_control;      // Delay loop control.
  logic [7:0] rx_warning_control;   // Warning control byte.
  logic [7:0] rx_reserved_control;  // Reserved tuning byte.

  logic [7:0] set_a;                // Group A events placed at their flag positions.
  logic [7:0] set_b;                // Group B events placed at their flag positions.
  logic [7:0] pend_a_a;             // Group A bits pending on line A.
  logic [7:0] pend_a_b;             // Group A bits pending on line B.
  logic [7:0] pend_b_a;             // Group B bits pending on line A.
  logic [7:0] pend_b_b;             // Group B bits pending on line B.
  logic       next_request_line_a;  // Next value of line A.
  logic       next_request_line_b;  // Next value of line B.
  logic [7:0] next_reg_rdata;       // Read mux output.
  logic [14:0] next_phase_x100;     // Phase implied by the offset field.
  logic [14:0] phase_delta;         // Magnitude times step.

  // ****************************************************************
  // Event placement
  // ****************************************************************
  // Puts each event pulse at the bit of its flag register.
  always_comb
  begin
    set_a = dei_pkg::RST_ZERO;
    set_b = dei_pkg::RST_ZERO;
    set_a[dei_pkg::BIT_SYNC_LOST]   = ev_a.sync_lost;
    set_a[dei_pkg::BIT_SYNC_LOCKED] = ev_a.sync_locked;
    set_a[dei_pkg::BIT_SYNC_DONE]   = ev_a.sync_done;
    set_a[dei_pkg::BIT_MULT_LOST]   = ev_a.mult_lost;
    set_a[dei_pkg::BIT_MULT_LOCKED] = ev_a.mult_locked;
    set_b[dei_pkg::BIT_PARITY_FAIL] = ev_b.parity_fail;
    set_b[dei_pkg::BIT_SAMPLE_FAIL] = ev_b.sample_fail;
    set_b[dei_pkg::BIT_DLL_WARN]    = ev_b.dll_warn;
    set_b[dei_pkg::BIT_DLL_LOCKED]  = ev_b.dll_locked;
    set_b[dei_pkg::BIT_FIFO_UNDER]  = ev_b.fifo_under;
    set_b[dei_pkg::BIT_FIFO_OVER]   = ev_b.fifo_over;
  end

  // ****************************************************************
  // Sticky flags
  // ****************************************************************
  // Flags hold until cleared; a set in the clear cycle wins so no event is lost.
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      event_flags_group_a <= dei_pkg::RST_ZERO;
      event_flags_group_b <= dei_pkg::RST_ZERO;
    end
    else
    begin
      event_flags_group_a <= ((event_flags_group_a & ~flag_clear_a) | set_a)
                             & dei_pkg::MASK_GROUP_A;
      event_flags_group_b <= ((event_flags_group_b & ~flag_clear_b) | set_b)
                             & dei_pkg::MASK_GROUP_B;
    end
  end

  // ****************************************************************
  // Gating and routing
  // ****************************************************************
  // Each flag bit is gated by its enable and steered by its select bit.
  for (genvar i = 0; i < 8; i++)
  begin : g_route
    assign pend_a_a[i] = event_flags_group_a[i] & irq_enable_group_a[i]
                         & dei_pkg::MASK_GROUP_A[i] & ~irq_route_group_a[i];
    assign pend_a_b[i] = event_flags_group_a[i] & irq_enable_group_a[i]
                         & dei_pkg::MASK_GROUP_A[i] & irq_route_group_a[i];
    assign pend_b_a[i] = event_flags_group_b[i] & irq_enable_group_b[i]
                         & ~irq_route_group_b[i];
    assign pend_b_b[i] = event_flags_group_b[i] & irq_enable_group_b[i]
                         & irq_route_group_b[i];
  end

  // The request lines are any pending bit of either group on that line.
  always_comb
  begin
    next_request_line_a = |{pend_a_a, pend_b_a};
    next_request_line_b = |{pend_a_b, pend_b_b};
  end

  // Registers the request lines so they are glitch free at the pins.
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      request_line_a <= 1'b0;
      request_line_b <= 1'b0;
    end
    else
    begin
      request_line_a <= next_request_line_a;
      request_line_b <= next_request_line_b;
    end
  end

  // ****************************************************************
  // Writable registers
  // ****************************************************************
  // Stores writes at the mapped offsets; flag registers ignore writes.
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      irq_enable_group_b  <= dei_pkg::RST_ZERO;
      irq_route_group_a   <= dei_pkg::RST_ZERO;
      irq_route_group_b   <= dei_pkg::RST_ZERO;
      shared_pin_usage    <= dei_pkg::RST_ZERO;
      rx_loop_control     <= dei_pkg::RST_RX_LOOP_CONTROL;
      rx_warning_control  <= dei_pkg::RST_RX_WARNING_CTRL;
      rx_reserved_control <= dei_pkg::RST_RX_RESERVED_CTRL;
    end
    else if (reg_wr)
    begin
      unique case (reg_addr)
        dei_pkg::OFS_IRQ_ENABLE_GROUP_B:
          irq_enable_group_b  <= reg_wdata & dei_pkg::MASK_GROUP_B;
        dei_pkg::OFS_IRQ_ROUTE_GROUP_A:
          irq_route_group_a   <= reg_wdata & dei_pkg::MASK_GROUP_A;
        dei_pkg::OFS_IRQ_ROUTE_GROUP_B:
          irq_route_group_b   <= reg_wdata & dei_pkg::MASK_GROUP_B;
        dei_pkg::OFS_SHARED_PIN_USAGE:
          shared_pin_usage    <= reg_wdata & dei_pkg::MASK_PIN_USAGE;
        dei_pkg::OFS_RX_LOOP_CONTROL:
          rx_loop_control     <= reg_wdata & dei_pkg::MASK_LOOP_CTRL;
        dei_pkg::OFS_RX_WARNING_CONTROL:
          rx_warning_control  <= reg_wdata;
        dei_pkg::OFS_RX_RESERVED_CONTROL:
          rx_reserved_control <= reg_wdata;
        default:
          ; // Read-only and unmapped offsets keep their contents.
      endcase
    end
  end

  // Pulses the warning clear for one cycle when its command bit is written as one.
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      rx_warn_clear <= 1'b0;
    end
    else
    begin
      rx_warn_clear <= reg_wr && (reg_addr == dei_pkg::OFS_RX_WARNING_CONTROL)
                       && reg_wdata[dei_pkg::BIT_WARN_CLEAR];
    end
  end

  // ****************************************************************
  // Read path
  // ****************************************************************
  // Selects the addressed register; unmapped offsets read as zero.
  always_comb
  begin
    unique case (reg_addr)
      dei_pkg::OFS_IRQ_ENABLE_GROUP_B:  next_reg_rdata = irq_enable_group_b;
      dei_pkg::OFS_EVENT_FLAGS_GROUP_A: next_reg_rdata = event_flags_group_a;
      dei_pkg::OFS_EVENT_FLAGS_GROUP_B: next_reg_rdata = event_flags_group_b;
      dei_pkg::OFS_IRQ_ROUTE_GROUP_A:   next_reg_rdata = irq_route_group_a;
      dei_pkg::OFS_IRQ_ROUTE_GROUP_B:   next_reg_rdata = irq_route_group_b;
      dei_pkg::OFS_SHARED_PIN_USAGE:    next_reg_rdata = shared_pin_usage;
      dei_pkg::OFS_RX_LOOP_CONTROL:     next_reg_rdata = rx_loop_control;
      dei_pkg::OFS_RX_WARNING_CONTROL:  next_reg_rdata = rx_warning_control;
      dei_pkg::OFS_RX_RESERVED_CONTROL: next_reg_rdata = rx_reserved_control;
      default:                          next_reg_rdata = dei_pkg::RST_ZERO;
    endcase
  end

  // Captures read data on the read strobe and holds it until the next read.
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      reg_rdata <= dei_pkg::RST_ZERO;
    end
    else if (reg_rd)
    begin
      reg_rdata <= next_reg_rdata;
    end
  end

  // ****************************************************************
  // Receiver control decode
  // ****************************************************************
  // Offset is signed magnitude: bit 3 is the sign, bits 2 to 0 the step count.
  always_comb
  begin
    phase_delta = 15'(rx_loop_control[2:0]) * dei_pkg::PHASE_STEP_X100;
    if (rx_loop_control[dei_pkg::BIT_OFFSET_SIGN])
    begin
      next_phase_x100 = dei_pkg::PHASE_BASE_X100 - phase_delta;
    end
    else
    begin
      next_phase_x100 = dei_pkg::PHASE_BASE_X100 + phase_delta;
    end
  end

  // Registers the receiver settings seen by the data interface.
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      rx_ctrl <= '0;
    end
    else
    begin
      rx_ctrl.dll_enable     <= rx_loop_control[dei_pkg::BIT_DLL_ENABLE];
      rx_ctrl.duty_corr_en   <= rx_loop_control[dei_pkg::BIT_DUTY_CORR];
      rx_ctrl.phase_offset   <= rx_loop_control[3:0];
      rx_ctrl.phase_x100     <= next_phase_x100;
      rx_ctrl.parity_sel     <= shared_pin_usage[1:0] == dei_pkg::PIN_PARITY;
      rx_ctrl.frame_sel      <= shared_pin_usage[1:0] == dei_pkg::PIN_FRAME;
      rx_ctrl.parity_in_use  <= shared_pin_usage[dei_pkg::BIT_PARITY_IN_USE];
      rx_ctrl.framing_in_use <= shared_pin_usage[dei_pkg::BIT_FRAMING_IN_USE];
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  // A parity event is visible in flag B bit 7 at the next edge.
  property p_parity_sets;
    @(posedge clk) disable iff (!resetn)
    ev_b.parity_fail |=> event_flags_group_b[dei_pkg::BIT_PARITY_FAIL];
  endproperty
  a_parity_sets: assert property (p_parity_sets)
    else $error("parity flag not set");

  // A sample compare event sets its flag even during a clear.
  property p_sample_sets;
    @(posedge clk) disable iff (!resetn)
    ev_b.sample_fail && flag_clear_b[dei_pkg::BIT_SAMPLE_FAIL]
      |=> event_flags_group_b[dei_pkg::BIT_SAMPLE_FAIL];
  endproperty
  a_sample_sets: assert property (p_sample_sets)
    else $error("sample flag lost under clear");

  // A FIFO underflow sets bit 2 and not the overflow bit on its own.
  property p_under_sets;
    @(posedge clk) disable iff (!resetn)
    ev_b.fifo_under && !ev_b.fifo_over && !event_flags_group_b[dei_pkg::BIT_FIFO_OVER]
      |=> event_flags_group_b[dei_pkg::BIT_FIFO_UNDER]
          && !event_flags_group_b[dei_pkg::BIT_FIFO_OVER];
  endproperty
  a_under_sets: assert property (p_under_sets)
    else $error("underflow flag wrong");

  // Sync done lands on group A bit 4.
  property p_sync_done_sets;
    @(posedge clk) disable iff (!resetn)
    ev_a.sync_done |=> event_flags_group_a[dei_pkg::BIT_SYNC_DONE];
  endproperty
  a_sync_done_sets: assert property (p_sync_done_sets)
    else $error("sync done flag not set");

  // Without clear or event, a set flag stays set.
  property p_flag_holds;
    @(posedge clk) disable iff (!resetn)
    event_flags_group_b[dei_pkg::BIT_DLL_LOCKED] && !flag_clear_b[dei_pkg::BIT_DLL_LOCKED]
      |=> event_flags_group_b[dei_pkg::BIT_DLL_LOCKED];
  endproperty
  a_flag_holds: assert property (p_flag_holds)
    else $error("flag dropped without clear");

  // A disabled group B flag never raises a line by itself.
  property p_b_disabled_quiet;
    @(posedge clk) disable iff (!resetn)
    (irq_enable_group_b == dei_pkg::RST_ZERO) && !(|(event_flags_group_a & irq_enable_group_a))
      |=> !request_line_a && !request_line_b;
  endproperty
  a_b_disabled_quiet: assert property (p_b_disabled_quiet)
    else $error("line raised with enables off");

  // A pending flag routed to line B raises line B, not A alone.
  property p_route_b;
    @(posedge clk) disable iff (!resetn)
    event_flags_group_b[dei_pkg::BIT_DLL_WARN] && irq_enable_group_b[dei_pkg::BIT_DLL_WARN]
      && irq_route_group_b[dei_pkg::BIT_DLL_WARN] |=> request_line_b;
  endproperty
  a_route_b: assert property (p_route_b)
    else $error("routed flag missed line B");

  // A group A flag enabled externally and routed to A raises line A.
  property p_group_a_gate;
    @(posedge clk) disable iff (!resetn)
    event_flags_group_a[dei_pkg::BIT_MULT_LOST] && irq_enable_group_a[dei_pkg::BIT_MULT_LOST]
      && !irq_route_group_a[dei_pkg::BIT_MULT_LOST] |=> request_line_a;
  endproperty
  a_group_a_gate: assert property (p_group_a_gate)
    else $error("group A flag missed line A");

  // The warning clear pulse lasts exactly one cycle after the command write.
  property p_warn_pulse;
    @(posedge clk) disable iff (!resetn)
    reg_wr && reg_addr == dei_pkg::OFS_RX_WARNING_CONTROL && reg_wdata[dei_pkg::BIT_WARN_CLEAR]
      ##1 !reg_wr |-> rx_warn_clear ##1 !rx_warn_clear;
  endproperty
  a_warn_pulse: assert property (p_warn_pulse)
    else $error("warning clear pulse wrong");

  // Two cycles after a loop control write the enables follow its bits.
  property p_loop_enables;
    @(posedge clk) disable iff (!resetn)
    reg_wr && reg_addr == dei_pkg::OFS_RX_LOOP_CONTROL ##1 !reg_wr
      |=> rx_ctrl.dll_enable == $past(reg_wdata[dei_pkg::BIT_DLL_ENABLE], 2)
          && rx_ctrl.duty_corr_en == $past(reg_wdata[dei_pkg::BIT_DUTY_CORR], 2);
  endproperty
  a_loop_enables: assert property (p_loop_enables)
    else $error("loop enables do not follow write");

  // Zero offset gives exactly the base phase.
  property p_phase_base;
    @(posedge clk) disable iff (!resetn)
    rx_loop_control[2:0] == 3'h0 |=> rx_ctrl.phase_x100 == dei_pkg::PHASE_BASE_X100;
  endproperty
  a_phase_base: assert property (p_phase_base)
    else $error("phase not at base");

  // The reserved usage code selects neither function.
  property p_pin_reserved;
    @(posedge clk) disable iff (!resetn)
    shared_pin_usage[1:0] == dei_pkg::PIN_RESERVED |=> !rx_ctrl.parity_sel && !rx_ctrl.frame_sel;
  endproperty
  a_pin_reserved: assert property (p_pin_reserved)
    else $error("reserved pin code selected a function");

endmodule

// ---- verif/dei_host_model.sv ----
// Host processor model that drives the byte register port of the event block.
// Assumes the block takes strobes on the rising edge of clk.
`timescale 1ns/100ps
module dei_host_model
(
  input  wire logic       clk,        // Device clock.
  input  wire logic [7:0] reg_rdata,  // Registered read data.
  output logic      [6:0] reg_addr,   // Register offset.
  output logic      [7:0] reg_wdata,  // Write data.
  output logic            reg_wr,     // Write strobe.
  output logic            reg_rd      // Read strobe.
);
  initial {reg_addr, reg_wdata, reg_wr, reg_rd} = '0;
  // One-cycle write strobe; released data is inverted so it never looks held.
  task automatic wr(input logic [6:0] a, input logic [7:0] v);
    @(posedge clk) #1;
    reg_addr = a;
    reg_wdata = v;
    reg_wr = 1'b1;
    @(posedge clk) #1;
    reg_wr = 1'b0;
    reg_wdata = ~v;
  endtask
  // One-cycle read strobe; the answer is taken after it has been registered.
  task automatic rd(input logic [6:0] a, output logic [7:0] v);
    @(posedge clk) #1;
    reg_addr = a;
    reg_rd = 1'b1;
    @(posedge clk) #1;
    reg_rd = 1'b0;
    @(posedge clk) #1;
    v = reg_rdata;
  endtask
endmodule

// ---- verif/dei_event_irq_tb.sv ----
// Self-checking bench of the event block: registers, flags, request lines, receiver control.
// Assumes the host model drives the register port and the bench drives the event inputs.
`timescale 1ns/100ps
module dei_event_irq_tb;
  logic                  clk = 1'b0;      // 40 MHz clock.
  logic                  resetn = 1'b0;   // Synchronous reset, active low.
  logic [6:0]            reg_addr;        // Offset from the host.
  logic [7:0]            reg_wdata;       // Write data from the host.
  logic                  reg_wr;          // Write strobe.
  logic                  reg_rd;          // Read strobe.
  logic [7:0]            reg_rdata;       // Read data.
  dei_pkg::dei_group_a_s ev_a = '0;       // Group A pulses.
  dei_pkg::dei_group_b_s ev_b = '0;       // Group B pulses.
  logic [7:0]            en_a = 8'h00;    // External group A enables.
  logic [7:0]            clr_a = 8'h00;   // Group A clear mask.
  logic [7:0]            clr_b = 8'h00;   // Group B clear mask.
  logic                  line_a;          // First request line.
  logic                  line_b;          // Second request line.
  dei_pkg::dei_rx_ctrl_s rx;              // Receiver controls.
  logic                  warn_clr;        // Warning clear pulse.
  logic [7:0]            d;               // Last read value.
  int                    error_cnt = 0;   // Mismatches.
  int                    checked = 0;     // Comparisons.
  int                    pulses = 0;      // Warning clear cycles seen.
  logic [7:0] rst_v [10] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h40, 8'h39, 8'h64, 8'h00};
  logic [6:0] wm_a [6] = '{7'h04, 7'h05, 7'h07, 7'h08, 7'h09, 7'h0A};
  logic [7:0] wm_v [6] = '{8'hF6, 8'h00, 8'h7C, 8'hF6, 8'h33, 8'hCF};
  logic [7:0] pin_w [4] = '{8'h00, 8'h21, 8'h12, 8'h03};
  logic [3:0] pin_e [4] = '{4'h0, 4'hA, 4'h5, 4'h0};
  always #12.5 clk = ~clk;
  // Counts every cycle in which the warning clear pulse stands.
  always @(posedge clk) if (warn_clr === 1'b1) pulses++;
  dei_event_irq dei_event_irq_i (.clk(clk), .resetn(resetn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .ev_a(ev_a), .ev_b(ev_b), .irq_enable_group_a(en_a), .flag_clear_a(clr_a),
    .flag_clear_b(clr_b), .request_line_a(line_a), .request_line_b(line_b),
    .rx_ctrl(rx), .rx_warn_clear(warn_clr));
  dei_host_model dei_host_model_i (.clk(clk), .reg_rdata(reg_rdata), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd));
  // Compares a seen value with an expected one.
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e)
    begin
      $display("BAD %0t seen %0h expected %0h", $time, s, e);
      error_cnt++;
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic rc(input logic [6:0] a, input logic [7:0] e);
    dei_host_model_i.rd(a, d);
    chk(d, e);
  endtask
  task automatic wrap_up();
    $display("errors %0d checks %0d", error_cnt, checked);
    if (error_cnt == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // Cuts a hang short.
  initial
  begin
    #60000;
    error_cnt++;
    wrap_up();
  end
  initial
  begin
    tick(3);
    resetn = 1'b1;
    tick(2);
    chk({rx.duty_corr_en, rx.phase_x100}, {1'b1, 15'h2328});
    foreach (rst_v[i]) rc(7'(4 + i), rst_v[i]);
    foreach (wm_a[i])
    begin
      dei_host_model_i.wr(wm_a[i], 8'hFF);
      rc(wm_a[i], wm_v[i]);
    end
    en_a = 8'h7C;
    ev_a = '1;
    ev_b = '1;
    tick(1);
    ev_a = '0;
    ev_b = '0;
    tick(3);
    chk({line_a, line_b}, 2'b01);
    rc(7'h06, 8'hF6);
    rc(7'h05, 8'h7C);
    clr_b = 8'hFF;
    tick(3);
    chk(line_b, 1'b1);
    en_a = 8'h00;
    tick(3);
    chk(line_b, 1'b0);
    clr_a = 8'hFF;
    ev_b.sample_fail = 1'b1;
    tick(1);
    {clr_a, clr_b} = '0;
    ev_b = '0;
    rc(7'h06, 8'h40);
    dei_host_model_i.wr(7'h08, 8'h00);
    dei_host_model_i.wr(7'h04, 8'h80);
    ev_b.fifo_under = 1'b1;
    tick(1);
    ev_b = '0;
    tick(3);
    chk(line_a, 1'b0);
    ev_b.parity_fail = 1'b1;
    tick(1);
    ev_b = '0;
    tick(3);
    chk({line_a, line_b}, 2'b10);
    rc(7'h06, 8'hC4);
    foreach (pin_w[i])
    begin
      dei_host_model_i.wr(7'h09, pin_w[i]);
      tick(2);
      chk({rx.parity_sel, rx.frame_sel, rx.parity_in_use, rx.framing_in_use}, pin_e[i]);
    end
    dei_host_model_i.wr(7'h0A, 8'h8B);
    tick(2);
    chk({rx.dll_enable, rx.duty_corr_en, rx.phase_x100}, {2'b10, 15'h15F9});
    chk(rx.phase_offset, 4'hB);
    dei_host_model_i.wr(7'h0A, 8'h45);
    tick(2);
    chk({rx.duty_corr_en, rx.phase_offset, rx.phase_x100}, {1'b1, 4'h5, 15'h3921});
    dei_host_model_i.wr(7'h0B, 8'hB9);
    tick(3);
    chk(pulses, 1);
    dei_host_model_i.wr(7'h0B, 8'h39);
    tick(3);
    chk(pulses, 1);
    wrap_up();
  end
endmodule
